//--- common/slot_conv_pkg.sv
package slot_conv_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int SLOTS = 8;
  localparam int CHANS = 8;
  localparam int SLOT_W = 3;
  localparam int CHAN_W = 3;
  localparam int ROUTE_W = 4;
  localparam int COEF_W = 8;
  localparam int RESULT_W = 16;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_SLOT_COUNT = 8'h04;
  localparam logic [7:0] OFS_SLOT_PICK = 8'h08;
  localparam logic [7:0] OFS_INPUT_ROUTE = 8'h0C;
  localparam logic [7:0] OFS_COEF_BASE = 8'h10;
  localparam logic [7:0] OFS_RESULT_BASE = 8'h30;
  localparam logic [7:0] OFS_STATUS = 8'h50;

  // control and status bit positions
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_READ_REQ_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_SLOT_LSB = 4;
  localparam int STAT_CHAN_LSB = 8;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [SLOT_W-1:0] SLOT_COUNT_RESET = 3'h0;
  localparam logic [SLOTS*CHAN_W-1:0] SLOT_PICK_RESET = 24'hFAC688;
  localparam logic [CHANS*ROUTE_W-1:0] INPUT_ROUTE_RESET = 32'h76543210;
  localparam logic [COEF_W-1:0] COEF_RESET = 8'hFF;
  localparam logic [RESULT_W-1:0] RESULT_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // analog input route codes
  // ----------------------------------------------------------------
  localparam logic [ROUTE_W-1:0] ROUTE_TEMP_SENSOR = 4'h0;
  localparam logic [ROUTE_W-1:0] ROUTE_FILTERED_INPUT_FOUR = 4'h1;
  localparam logic [ROUTE_W-1:0] ROUTE_FILTERED_INPUT_FIVE = 4'h2;
  localparam logic [ROUTE_W-1:0] ROUTE_FILTERED_INPUT_SIX = 4'h3;
  localparam logic [ROUTE_W-1:0] ROUTE_FILTERED_INPUT_SEVEN = 4'h4;
  localparam logic [ROUTE_W-1:0] ROUTE_NO_CONNECT = 4'h5;
  localparam logic [ROUTE_W-1:0] ROUTE_ANALOG_SUPPLY_TAP = 4'h6;
  localparam logic [ROUTE_W-1:0] ROUTE_FILTERED_INPUT_TEN = 4'h7;
  localparam logic [ROUTE_W-1:0] ROUTE_FILTERED_INPUT_ELEVEN = 4'h8;
  localparam logic [ROUTE_W-1:0] ROUTE_FILTERED_INPUT_EIGHT = 4'h9;
  localparam logic [ROUTE_W-1:0] ROUTE_FILTERED_INPUT_NINE = 4'hA;
  localparam logic [ROUTE_W-1:0] ROUTE_GROUND = 4'hB;
  localparam logic [ROUTE_W-1:0] ROUTE_HIGH_GAIN_INPUT_ELEVEN = 4'hC;
  localparam logic [ROUTE_W-1:0] ROUTE_CAL_DAC = 4'hD;
  localparam logic [ROUTE_W-1:0] ROUTE_RESERVED_LOW = 4'hE;
  localparam logic [ROUTE_W-1:0] ROUTE_RESERVED_HIGH = 4'hF;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    SEQ_IDLE,
    SEQ_WAIT
  } seq_state_t;

endpackage

//--- rtl/slot_sequenced_converter.sv
// Function
// RULE1: eight independently configurable time slots form the repeating conversion order.
// RULE2: slot count zero cycles slots 0 through 7 ascending, then wraps.
// RULE3: slot count N from one to seven cycles slots 0 to N-1 only.
// RULE4: each slot holds a 3-bit channel pick naming the channel converted there.
// RULE5: route codes select temperature sensor and filtered inputs four to eleven.
// RULE6: code 0101b no connect; supply, ground, high gain, calibration DAC; 1110b/1111b reserved.
// RULE7: software sets slot count, then slot picks, then channel routes.
// RULE8: any channel may sit in any number of slots, in any order.
// RULE9: each channel smooths with its 8-bit coefficient, reset 255, into a 16-bit result.
// RULE10: the temperature sensor is digitized through its own route code.
// RULE11: software sets a read request flag; hardware clears it when data is ready.
// RULE12: result moves toward each sample by the coefficient-scaled difference.
`timescale 1ns/1ps

module slot_sequenced_converter
  import slot_conv_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  output logic [DATA_W-1:0] reg_rdata_out,
  output logic conv_start_out,
  output logic [ROUTE_W-1:0] mux_route_out,
  input wire logic sample_valid_in,
  input wire logic [RESULT_W-1:0] sample_in
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    // control and configuration
    logic run;
    logic read_req;
    logic [SLOT_W-1:0] slot_count;
    logic [SLOTS-1:0][CHAN_W-1:0] pick;
    logic [CHANS-1:0][ROUTE_W-1:0] route;
    logic [CHANS-1:0][COEF_W-1:0] coef;
    // live smoothed results and the copy software reads
    logic [CHANS-1:0][RESULT_W-1:0] result;
    logic [CHANS-1:0][RESULT_W-1:0] snap;
    // sequencer position and converter link outputs
    seq_state_t seq;
    logic [SLOT_W-1:0] slot;
    logic [CHAN_W-1:0] chan;
    logic [ROUTE_W-1:0] mux;
    logic start;
    // read answer, stands one cycle
    logic [DATA_W-1:0] rdata;
  } conv_state_t;

  localparam conv_state_t STATE_RESET = '{
    run: 1'b0,
    read_req: 1'b0,
    slot_count: SLOT_COUNT_RESET,
    pick: SLOT_PICK_RESET,
    route: INPUT_ROUTE_RESET,
    coef: {CHANS{COEF_RESET}},
    result: {CHANS{RESULT_RESET}},
    snap: {CHANS{RESULT_RESET}},
    seq: SEQ_IDLE,
    slot: 3'h0,
    chan: 3'h0,
    mux: ROUTE_TEMP_SENSOR,
    start: 1'b0,
    rdata: 32'h00000000
  };

  conv_state_t state_reg;
  conv_state_t state_next;
  logic [RESULT_W-1:0] filtered;

  // ----------------------------------------------------------------
  // local constants
  // ----------------------------------------------------------------
  // each register window holds one word per channel
  localparam logic [ADDR_W-1:0] WINDOW_SPAN = 8'h20;
  localparam logic [SLOT_W-1:0] FIRST_SLOT = 3'h0;
  localparam logic [SLOT_W-1:0] LAST_SLOT_ALL = 3'h7;
  localparam logic [SLOT_W-1:0] SLOT_STEP = 3'h1;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [SLOT_W-1:0] last_slot(input logic [SLOT_W-1:0] count);
    // zero means all eight slots
    last_slot = (count == '0) ? LAST_SLOT_ALL : count - SLOT_STEP;
  endfunction

  function automatic logic [SLOT_W-1:0] next_slot(input logic [SLOT_W-1:0] slot,
                                                 input logic [SLOT_W-1:0] count);
    // also recovers when the count shrinks below the current slot
    next_slot = (slot >= last_slot(count)) ? FIRST_SLOT : slot + SLOT_STEP;
  endfunction

  function automatic logic [ROUTE_W-1:0] mux_code(input logic [ROUTE_W-1:0] code);
    // reserved codes leave the converter input unconnected
    if (code == ROUTE_RESERVED_LOW || code == ROUTE_RESERVED_HIGH)
      mux_code = ROUTE_NO_CONNECT;
    else
      mux_code = code;
  endfunction

  function automatic logic in_window(input logic [ADDR_W-1:0] addr,
                                     input logic [ADDR_W-1:0] base);
    in_window = (addr >= base) && (addr < base + WINDOW_SPAN) && (addr[1:0] == 2'h0);
  endfunction

  function automatic logic [CHAN_W-1:0] win_index(input logic [ADDR_W-1:0] addr,
                                                  input logic [ADDR_W-1:0] base);
    // word offset inside a window; window bases are not aligned to its span
    logic [ADDR_W-1:0] ofs;
    ofs = addr - base;
    win_index = ofs[CHAN_W+1:2];
  endfunction

  function automatic logic [DATA_W-1:0] status_word(input logic busy,
                                                    input logic [SLOT_W-1:0] slot,
                                                    input logic [CHAN_W-1:0] chan);
    status_word = '0;
    status_word[STAT_BUSY_BIT] = busy;
    status_word[STAT_SLOT_LSB +: SLOT_W] = slot;
    status_word[STAT_CHAN_LSB +: CHAN_W] = chan;
  endfunction

  // ----------------------------------------------------------------
  // smoothing filter
  // ----------------------------------------------------------------
  // RULE12 recursive average
  smoothing_filter filter_u (
    .prev_in(state_reg.result[state_reg.chan]),
    .sample_in(sample_in),
    .coef_in(state_reg.coef[state_reg.chan]),
    .result_out(filtered)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [CHAN_W-1:0] pick_now;
    logic [CHAN_W-1:0] idx;
    logic issue;
    pick_now = 3'h0;
    idx = 3'h0;
    issue = 1'b0;
    state_next = state_reg;
    state_next.start = 1'b0;

    // sequencer
    case (state_reg.seq)
      SEQ_IDLE:
      begin
        issue = state_reg.run;
        // RULE11 clear when idle
        if (state_reg.read_req)
        begin
          state_next.snap = state_reg.result;
          state_next.read_req = 1'b0;
        end
      end
      SEQ_WAIT:
      begin
        if (sample_valid_in)
        begin
          // RULE9 store smoothed result
          state_next.result[state_reg.chan] = filtered;
          // RULE2 RULE3 slot advance
          state_next.slot = next_slot(state_reg.slot, state_reg.slot_count);
          // RULE11 data ready clears
          if (state_reg.read_req)
          begin
            state_next.snap = state_next.result;
            state_next.read_req = 1'b0;
          end
          issue = state_reg.run;
          state_next.seq = SEQ_IDLE;
        end
      end
      default:
      begin
        state_next.seq = SEQ_IDLE;
      end
    endcase

    if (issue)
    begin
      // route is latched with the start and holds for the whole conversion
      // RULE1 RULE4 RULE8 slot to channel
      pick_now = state_reg.pick[state_next.slot];
      state_next.chan = pick_now;
      // RULE5 RULE6 RULE10 channel to input
      state_next.mux = mux_code(state_reg.route[pick_now]);
      state_next.start = 1'b1;
      state_next.seq = SEQ_WAIT;
    end

    // register writes; a software set of the read request wins
    if (reg_wr_in)
    begin
      case (reg_addr_in)
        OFS_CONTROL:
        begin
          state_next.run = reg_wdata_in[CTRL_RUN_BIT];
          // RULE11 software set
          if (reg_wdata_in[CTRL_READ_REQ_BIT])
            state_next.read_req = 1'b1;
        end
        OFS_SLOT_COUNT:
        begin
          state_next.slot_count = reg_wdata_in[SLOT_W-1:0];
        end
        OFS_SLOT_PICK:
        begin
          state_next.pick = reg_wdata_in[SLOTS*CHAN_W-1:0];
        end
        OFS_INPUT_ROUTE:
        begin
          state_next.route = reg_wdata_in[CHANS*ROUTE_W-1:0];
        end
        default:
        begin
          if (in_window(reg_addr_in, OFS_COEF_BASE))
          begin
            idx = win_index(reg_addr_in, OFS_COEF_BASE);
            state_next.coef[idx] = reg_wdata_in[COEF_W-1:0];
          end
        end
      endcase
    end

    // register reads, answered one cycle later
    state_next.rdata = 32'h00000000;
    if (reg_rd_in)
    begin
      case (reg_addr_in)
        OFS_CONTROL:
        begin
          state_next.rdata[CTRL_RUN_BIT] = state_reg.run;
          state_next.rdata[CTRL_READ_REQ_BIT] = state_reg.read_req;
        end
        OFS_SLOT_COUNT:
        begin
          state_next.rdata[SLOT_W-1:0] = state_reg.slot_count;
        end
        OFS_SLOT_PICK:
        begin
          state_next.rdata[SLOTS*CHAN_W-1:0] = state_reg.pick;
        end
        OFS_INPUT_ROUTE:
        begin
          state_next.rdata = state_reg.route;
        end
        OFS_STATUS:
        begin
          // busy means a start went out and its sample is still owed
          state_next.rdata = status_word(state_reg.seq == SEQ_WAIT, state_reg.slot,
                                         state_reg.chan);
        end
        default:
        begin
          if (in_window(reg_addr_in, OFS_COEF_BASE))
          begin
            idx = win_index(reg_addr_in, OFS_COEF_BASE);
            state_next.rdata[COEF_W-1:0] = state_reg.coef[idx];
          end
          else if (in_window(reg_addr_in, OFS_RESULT_BASE))
          begin
            // results read the copy taken when the last read request was cleared
            idx = win_index(reg_addr_in, OFS_RESULT_BASE);
            state_next.rdata[RESULT_W-1:0] = state_reg.snap[idx];
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      state_reg <= STATE_RESET;
    else
      state_reg <= state_next;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign reg_rdata_out = state_reg.rdata;
  assign conv_start_out = state_reg.start;
  assign mux_route_out = state_reg.mux;

endmodule // slot_sequenced_converter

//--- rtl/smoothing_filter.sv
`timescale 1ns/1ps

module smoothing_filter
  import slot_conv_pkg::*;
(
  input wire logic [RESULT_W-1:0] prev_in,
  input wire logic [RESULT_W-1:0] sample_in,
  input wire logic [COEF_W-1:0] coef_in,
  output logic [RESULT_W-1:0] result_out
);

  // ----------------------------------------------------------------
  // first-order recursive average
  // ----------------------------------------------------------------
  logic signed [RESULT_W:0] diff;
  logic signed [RESULT_W+COEF_W+1:0] scaled;
  logic signed [RESULT_W+1:0] sum;

  always_comb
  begin
    diff = $signed({1'b0, sample_in}) - $signed({1'b0, prev_in});
    scaled = diff * $signed({1'b0, coef_in});
    // coefficient is a fraction of 256; arithmetic shift keeps the sign
    sum = $signed({2'b00, prev_in}) + $signed(scaled[RESULT_W+COEF_W+1:COEF_W]);
    result_out = sum[RESULT_W-1:0];
  end

endmodule // smoothing_filter

//--- test/converter_model.sv
`timescale 1ns/1ps

module converter_model
  import slot_conv_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic conv_start_in,
  input wire logic [ROUTE_W-1:0] route_in,
  input wire logic [7:0] lat_in,
  input wire logic [RESULT_W-1:0] level_in,
  output logic sample_valid_out,
  output logic [RESULT_W-1:0] sample_out
);
  logic busy;
  logic [7:0] wait_q;
  // ----------------------------------------------------------------
  // converter: one sample per start, valid lat_in + 2 cycles after the start pulse
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in)
    begin
      busy <= 1'b0;
      wait_q <= '0;
      sample_valid_out <= 1'b0;
      sample_out <= 16'h5A5A;
    end
    else
    begin
      sample_valid_out <= 1'b0;
      // sample line toggles outside its valid cycle
      sample_out <= ~sample_out;
      if (conv_start_in)
      begin
        busy <= 1'b1;
        wait_q <= lat_in;
      end
      else if (busy && wait_q == 8'h00)
      begin
        busy <= 1'b0;
        sample_valid_out <= 1'b1;
        sample_out <= level_in ^ {12'h000, route_in};
      end
      else if (busy)
        wait_q <= wait_q - 8'h01;
    end
endmodule // converter_model

//--- test/slot_conv_sva.sv
`timescale 1ns/1ps

module slot_conv_sva
  import slot_conv_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  input wire logic [DATA_W-1:0] reg_rdata_out,
  input wire logic conv_start_out,
  input wire logic [ROUTE_W-1:0] mux_route_out,
  input wire logic sample_valid_in,
  input wire logic [RESULT_W-1:0] sample_in
);
  // ----------------------------------------------------------------
  // shadow of run, slot count and converter busy
  // ----------------------------------------------------------------
  logic busy_q;
  logic run_q;
  logic [SLOT_W-1:0] cnt_q;
  wire ctl_wr = reg_wr_in && reg_addr_in == OFS_CONTROL;
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in)
    begin
      busy_q <= 1'b0;
      run_q <= 1'b0;
      cnt_q <= '0;
    end
    else
    begin
      busy_q <= conv_start_out || (busy_q && !sample_valid_in);
      if (ctl_wr)
        run_q <= reg_wdata_in[CTRL_RUN_BIT];
      if (reg_wr_in && reg_addr_in == OFS_SLOT_COUNT)
        cnt_q <= reg_wdata_in[SLOT_W-1:0];
    end

  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_rdata_quiet: assert property (
    !$past(reg_rd_in) |-> reg_rdata_out == '0) else $error("read data not zero");
  a_count_read: assert property (
    reg_rd_in && reg_addr_in == OFS_SLOT_COUNT && !reg_wr_in |=> reg_rdata_out == 32'(cnt_q))
    else $error("slot count readback wrong");
  a_start_pulse: assert property (
    conv_start_out |=> !conv_start_out) else $error("start longer than one cycle");
  a_route_hold: assert property (
    !conv_start_out |-> $stable(mux_route_out)) else $error("route moved without start");
  a_route_legal: assert property (
    mux_route_out < 4'hE) else $error("reserved route driven");
  a_start_idle: assert property (
    conv_start_out |-> !busy_q) else $error("start while converting");
  a_first_start: assert property (
    $rose(run_q) && !busy_q |=> conv_start_out) else $error("no start after run");
  a_next_start: assert property (
    busy_q && sample_valid_in && run_q && !ctl_wr |=> conv_start_out)
    else $error("no start after sample");
  a_start_run: assert property (
    conv_start_out |-> $past(run_q)) else $error("start while stopped");

  c_start: cover property (conv_start_out);
  c_sample: cover property (busy_q && sample_valid_in);
  c_ctl_read: cover property (reg_rd_in && reg_addr_in == OFS_CONTROL);
endmodule // slot_conv_sva

bind slot_sequenced_converter slot_conv_sva u_sva (
  .clk_in(clk_in),
  .rst_in(rst_in),
  .reg_addr_in(reg_addr_in),
  .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in),
  .reg_wdata_in(reg_wdata_in),
  .reg_rdata_out(reg_rdata_out),
  .conv_start_out(conv_start_out),
  .mux_route_out(mux_route_out),
  .sample_valid_in(sample_valid_in),
  .sample_in(sample_in)
);

//--- test/test_slot_sequenced_converter.sv
`timescale 1ns/1ps

module test_slot_sequenced_converter;
  import slot_conv_pkg::*;
  logic clk_in = 0, rst_in = 1, reg_wr_in = 0, reg_rd_in = 0, sample_valid_in, conv_start_out;
  logic [7:0] reg_addr_in = 0, lat = 0;
  logic [31:0] reg_wdata_in = 0, reg_rdata_out, pk, rt;
  logic [3:0] mux_route_out, route[8];
  logic [15:0] sample_in, level = 0, res[8];
  logic [2:0] pick[8];
  logic [7:0] coef[8];
  int fails = 0, n_compared = 0, seed = 32'h9bab, slot, last, ch_now;

  slot_sequenced_converter dut (.clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .conv_start_out(conv_start_out),
    .mux_route_out(mux_route_out), .sample_valid_in(sample_valid_in), .sample_in(sample_in));
  converter_model u_model (.clk_in(clk_in), .rst_in(rst_in), .conv_start_in(conv_start_out),
    .route_in(mux_route_out), .lat_in(lat), .level_in(level),
    .sample_valid_out(sample_valid_in), .sample_out(sample_in));

  initial forever #10 clk_in = ~clk_in;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] filt(logic [15:0] o, logic [15:0] s, logic [7:0] c);
    int d;
    d = int'(s) - int'(o);
    return 16'(int'(o) + ((d * int'(c)) >>> 8));
  endfunction
  function automatic logic [3:0] rmap(logic [3:0] r);
    return (r > 4'hD) ? ROUTE_NO_CONNECT : r;
  endfunction
  task automatic chk(string w, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(negedge clk_in);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1;
    @(negedge clk_in);
    reg_wr_in = 0;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e, string w);
    @(negedge clk_in);
    reg_addr_in = a;
    reg_rd_in = 1;
    @(negedge clk_in);
    reg_rd_in = 0;
    chk(w, e, reg_rdata_out);
  endtask
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // expected route per start and filtered result per sample
  always @(posedge clk_in)
    if (!rst_in && conv_start_out)
    begin
      chk("route", rmap(route[pick[slot]]), mux_route_out);
      ch_now = pick[slot];
      slot = (slot == last) ? 0 : slot + 1;
    end
    else if (!rst_in && sample_valid_in)
      res[ch_now] = filt(res[ch_now], sample_in, coef[ch_now]);

  task automatic run_case(logic [2:0] n, logic [7:0] l);
    @(negedge clk_in);
    rst_in = 1;
    @(negedge clk_in);
    rst_in = 0;
    lat = l;
    slot = 0;
    last = (n == 0) ? 7 : n - 1;
    for (int k = 0; k < 8; k++)
    begin
      pick[k] = 3'($random(seed));
      route[k] = 4'($random(seed));
      coef[k] = 8'($random(seed));
      res[k] = 0;
      pk[3*k+:3] = pick[k];
      rt[4*k+:4] = route[k];
    end
    wr(OFS_SLOT_COUNT, n);
    wr(OFS_SLOT_PICK, pk);
    wr(OFS_INPUT_ROUTE, rt);
    for (int k = 0; k < 8; k++)
      wr(OFS_COEF_BASE + 8'(4 * k), coef[k]);
    wr(OFS_CONTROL, 1);
    if (l > 20)
    begin
      wr(OFS_CONTROL, 3);
      rd(OFS_CONTROL, 3, "request busy");
    end
    repeat (20 * (l + 4))
    begin
      @(negedge clk_in);
      level = 16'($random(seed));
    end
    wr(OFS_CONTROL, 0);
    repeat (l + 8) @(negedge clk_in);
    wr(OFS_CONTROL, 2);
    rd(OFS_CONTROL, 0, "request idle");
    rd(OFS_STATUS, 32'(ch_now << STAT_CHAN_LSB | slot << STAT_SLOT_LSB), "status");
    for (int k = 0; k < 8; k++)
      rd(OFS_RESULT_BASE + 8'(4 * k), res[k], "result");
  endtask

  initial
  begin
    #(20 * 40000);
    fails++;
    give_verdict();
  end

  initial
  begin
    repeat (4) @(negedge clk_in);
    rst_in = 0;
    rd(OFS_SLOT_COUNT, 0, "count reset");
    rd(OFS_SLOT_PICK, SLOT_PICK_RESET, "pick reset");
    rd(OFS_INPUT_ROUTE, INPUT_ROUTE_RESET, "route reset");
    for (int k = 0; k < 8; k++)
      rd(OFS_COEF_BASE + 8'(4 * k), 32'hFF, "coef reset");
    wr(OFS_RESULT_BASE, 32'h1234);
    rd(OFS_RESULT_BASE, 0, "result read only");
    rd(8'h60, 0, "unmapped");
    run_case(0, 0);
    run_case(1, 3);
    run_case(7, 60);
    for (int i = 0; i < 4; i++)
      run_case(3'($random(seed)), 8'($random(seed)) & 8'h0F);
    give_verdict();
  end
endmodule // test_slot_sequenced_converter
